// ===== gatc_aux_timer.sv
module gatc_aux_timer #(
	parameter int CNT_W = 16
) (
	input wire logic I_CORE_CLK,
	input wire logic I_RESET_N,
	input wire logic [gatc_pkg::ADDR_W-1:0] I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [gatc_pkg::DATA_W-1:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	output logic [1:0] O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [gatc_pkg::ADDR_W-1:0] I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	output logic [gatc_pkg::DATA_W-1:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY,
	input wire logic I_AUX_B_COUNT_PIN,
	input wire logic I_AUX_B_DIRECTION_PIN,
	input wire logic I_CORE_RUN_BIT,
	input wire logic I_CORE_TOGGLE_LATCH,
	output logic O_CLEAR_AUX_A,
	output logic O_CLEAR_CORE,
	output logic O_AUX_B_RUN,
	output logic O_AUX_B_COUNT_DOWN,
	output logic O_IRQ
);
	// ****************************************
	// Declarations
	// ****************************************
	localparam int CW = gatc_pkg::CTRL_W;

	logic aw_hold, w_hold, next_aw_hold, next_w_hold;
	logic [gatc_pkg::ADDR_W-1:0] aw_addr, next_aw_addr;
	logic [gatc_pkg::DATA_W-1:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic next_awready, next_wready, next_bvalid, next_arready;
	logic next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [gatc_pkg::DATA_W-1:0] next_rdata;
	logic do_write;
	logic [gatc_pkg::ADDR_W-1:0] wr_word;
	logic [gatc_pkg::ADDR_W-1:0] rd_word;
	logic [gatc_pkg::DATA_W-1:0] wr_val;

	logic [CW-2:0] ctrl, next_ctrl;
	logic rot_dir, next_rot_dir;
	logic [gatc_pkg::ST_W-1:0] status, next_status, st_set;
	logic [gatc_pkg::ST_W-1:0] mask, next_mask;
	logic [1:0] bps, next_bps;
	logic [CNT_W-1:0] cnt, next_cnt;
	logic toggle_prev;
	logic next_clear_a, next_clear_core, next_run, next_irq;

	gatc_pkg::gatc_mode_t mode;
	logic [2:0] in_sel;
	logic run, dir, tick, presc_en, incremental;
	logic count_evt, edge_evt, tl_rise, tl_fall;

	gatc_edge_if count_pin ();
	gatc_edge_if dir_pin ();

	// ****************************************
	// Parameter check
	// ****************************************
	if (CNT_W < 2 || CNT_W > gatc_pkg::DATA_W) begin : g_bad_width
		$error("CNT_W must lie between 2 and the bus width");
	end

	// ****************************************
	// Pin synchronisers and prescaler
	// ****************************************
	gatc_edge_sync u_count_sync (
		.i_clk(I_CORE_CLK),
		.i_reset_n(I_RESET_N),
		.i_pin(I_AUX_B_COUNT_PIN),
		.o_edge(count_pin)
	);

	gatc_edge_sync u_dir_sync (
		.i_clk(I_CORE_CLK),
		.i_reset_n(I_RESET_N),
		.i_pin(I_AUX_B_DIRECTION_PIN),
		.o_edge(dir_pin)
	);

	gatc_prescaler u_presc (
		.i_clk(I_CORE_CLK),
		.i_reset_n(I_RESET_N),
		.i_enable(presc_en),
		.i_bps(bps),
		.i_sel(in_sel),
		.o_tick(tick)
	);

	// Byte-lane merge for partial writes
	function automatic logic [gatc_pkg::DATA_W-1:0] merge(
		input logic [gatc_pkg::DATA_W-1:0] old_v,
		input logic [gatc_pkg::DATA_W-1:0] new_v,
		input logic [3:0] strb
	);
		logic [gatc_pkg::DATA_W-1:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// Edge code decode shared by counter and capture modes
	function automatic logic pick(
		input logic [1:0] code,
		input logic rise,
		input logic fall
	);
		case (code)
			gatc_pkg::EDGE_RISE: pick = rise;
			gatc_pkg::EDGE_FALL: pick = fall;
			gatc_pkg::EDGE_ANY: pick = rise | fall;
			default: pick = 1'b0;
		endcase
	endfunction

	// ****************************************
	// Event selection
	// ****************************************
	always_comb begin
		mode = gatc_pkg::gatc_mode_t'(ctrl[gatc_pkg::MODE_LSB +: 3]);
		in_sel = ctrl[gatc_pkg::INSEL_LSB +: 3];
		if (ctrl[gatc_pkg::REMOTE_BIT]) begin
			run = I_CORE_RUN_BIT;
		end else begin
			run = ctrl[gatc_pkg::RUN_BIT];
		end
		if (ctrl[gatc_pkg::EXTDIR_BIT]) begin
			dir = dir_pin.level ^ ctrl[gatc_pkg::SWDIR_BIT];
		end else begin
			dir = ctrl[gatc_pkg::SWDIR_BIT];
		end
		tl_rise = I_CORE_TOGGLE_LATCH & ~toggle_prev;
		tl_fall = ~I_CORE_TOGGLE_LATCH & toggle_prev;
		presc_en = 1'b0;
		count_evt = 1'b0;
		edge_evt = 1'b0;
		incremental = 1'b0;
		case (mode)
			gatc_pkg::MODE_TIMER: begin
				presc_en = run;
				count_evt = tick;
			end
			gatc_pkg::MODE_GATED_LO: begin
				presc_en = run;
				count_evt = tick & ~count_pin.level;
			end
			gatc_pkg::MODE_GATED_HI: begin
				presc_en = run;
				count_evt = tick & count_pin.level;
			end
			gatc_pkg::MODE_COUNTER, gatc_pkg::MODE_RELOAD: begin
				// X00 decodes to no edge, so counting stops
				if (in_sel[2]) begin
					edge_evt = pick(in_sel[1:0], tl_rise, tl_fall);
				end else begin
					edge_evt = pick(in_sel[1:0], count_pin.rise,
						count_pin.fall);
				end
				count_evt = edge_evt;
			end
			gatc_pkg::MODE_CAPTURE: begin
				// Capture transfer itself lives in the core block
				if (!in_sel[2]) begin
					edge_evt = pick(in_sel[1:0], count_pin.rise,
						count_pin.fall);
				end
			end
			gatc_pkg::MODE_INC_ROT, gatc_pkg::MODE_INC_EDGE: begin
				incremental = 1'b1;
				case (in_sel)
					gatc_pkg::INC_COUNT_PIN:
						edge_evt = count_pin.rise | count_pin.fall;
					gatc_pkg::INC_DIR_PIN:
						edge_evt = dir_pin.rise | dir_pin.fall;
					gatc_pkg::INC_BOTH:
						edge_evt = count_pin.rise | count_pin.fall |
							dir_pin.rise | dir_pin.fall;
					default: edge_evt = 1'b0;
				endcase
				count_evt = edge_evt;
			end
			default: begin
				count_evt = 1'b0;
			end
		endcase
		count_evt = count_evt & run;
		edge_evt = edge_evt & run;
	end

	// ****************************************
	// AXI4-Lite handshake
	// ****************************************
	always_comb begin
		next_aw_hold = aw_hold;
		next_aw_addr = aw_addr;
		next_w_hold = w_hold;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = O_BVALID;
		next_bresp = O_BRESP;
		next_rvalid = O_RVALID;
		next_rresp = O_RRESP;
		next_rdata = O_RDATA;
		wr_word = {aw_addr[gatc_pkg::ADDR_W-1:2], 2'b00};
		rd_word = {I_ARADDR[gatc_pkg::ADDR_W-1:2], 2'b00};
		if (I_AWVALID && O_AWREADY) begin
			next_aw_hold = 1'b1;
			next_aw_addr = I_AWADDR;
		end
		if (I_WVALID && O_WREADY) begin
			next_w_hold = 1'b1;
			next_w_data = I_WDATA;
			next_w_strb = I_WSTRB;
		end
		do_write = aw_hold && w_hold && !O_BVALID;
		if (do_write) begin
			next_aw_hold = 1'b0;
			next_w_hold = 1'b0;
			next_bvalid = 1'b1;
			case (wr_word)
				gatc_pkg::CTRL_ADDR, gatc_pkg::STATUS_ADDR,
				gatc_pkg::MASK_ADDR, gatc_pkg::CONFIG_ADDR,
				gatc_pkg::COUNT_ADDR: next_bresp = gatc_pkg::RESP_OKAY;
				default: next_bresp = gatc_pkg::RESP_SLVERR;
			endcase
		end else if (O_BVALID && I_BREADY) begin
			next_bvalid = 1'b0;
		end
		next_awready = !next_aw_hold && !next_bvalid;
		next_wready = !next_w_hold && !next_bvalid;
		if (I_ARVALID && O_ARREADY) begin
			next_rvalid = 1'b1;
			next_rresp = gatc_pkg::RESP_OKAY;
			case (rd_word)
				gatc_pkg::CTRL_ADDR:
					next_rdata = gatc_pkg::DATA_W'({rot_dir, ctrl});
				gatc_pkg::STATUS_ADDR:
					next_rdata = gatc_pkg::DATA_W'(status);
				gatc_pkg::MASK_ADDR:
					next_rdata = gatc_pkg::DATA_W'(mask);
				gatc_pkg::CONFIG_ADDR:
					next_rdata = gatc_pkg::DATA_W'(bps);
				gatc_pkg::COUNT_ADDR:
					next_rdata = gatc_pkg::DATA_W'(cnt);
				default: begin
					next_rdata = '0;
					next_rresp = gatc_pkg::RESP_SLVERR;
				end
			endcase
		end else if (O_RVALID && I_RREADY) begin
			next_rvalid = 1'b0;
		end
		next_arready = !next_rvalid;
	end

	// ****************************************
	// Registers, flags and counter
	// ****************************************
	always_comb begin
		next_ctrl = ctrl;
		next_status = status;
		next_mask = mask;
		next_bps = bps;
		next_cnt = cnt;
		wr_val = '0;
		if (do_write) begin
			case (wr_word)
				gatc_pkg::CTRL_ADDR: begin
					wr_val = merge(gatc_pkg::DATA_W'(ctrl), w_data, w_strb);
					next_ctrl = wr_val[CW-2:0];
				end
				gatc_pkg::STATUS_ADDR: begin
					wr_val = merge('0, w_data, w_strb);
					next_status = status & ~wr_val[gatc_pkg::ST_W-1:0];
				end
				gatc_pkg::MASK_ADDR: begin
					wr_val = merge(gatc_pkg::DATA_W'(mask), w_data, w_strb);
					next_mask = wr_val[gatc_pkg::ST_W-1:0];
				end
				gatc_pkg::CONFIG_ADDR: begin
					wr_val = merge(gatc_pkg::DATA_W'(bps), w_data, w_strb);
					next_bps = wr_val[1:0];
				end
				gatc_pkg::COUNT_ADDR: begin
					wr_val = merge(gatc_pkg::DATA_W'(cnt), w_data, w_strb);
					next_cnt = wr_val[CNT_W-1:0];
				end
				default: begin
					wr_val = '0;
				end
			endcase
		end
		// Software write to the count wins over a same-cycle step
		if (!(do_write && wr_word == gatc_pkg::COUNT_ADDR) && count_evt) begin
			if (dir) begin
				next_cnt = cnt - 1'b1;
			end else begin
				next_cnt = cnt + 1'b1;
			end
		end
		// Hardware set beats a same-cycle software clear
		if (edge_evt) begin
			next_ctrl[gatc_pkg::EDGE_BIT] = 1'b1;
		end
		if (dir != rot_dir) begin
			next_ctrl[gatc_pkg::DIRCHG_BIT] = 1'b1;
		end
		next_rot_dir = dir;
		st_set = '0;
		if (!(incremental && ctrl[gatc_pkg::IRQDIS_BIT])) begin
			st_set[gatc_pkg::ST_EDGE] = edge_evt;
			st_set[gatc_pkg::ST_DIRCHG] = dir != rot_dir;
		end
		next_clear_a = ctrl[gatc_pkg::CLR_A_BIT] & dir_pin.fall;
		next_clear_core = ctrl[gatc_pkg::CLR_CORE_BIT] &
			count_pin.fall;
		st_set[gatc_pkg::ST_CLR_A] = next_clear_a;
		st_set[gatc_pkg::ST_CLR_CORE] = next_clear_core;
		next_status = next_status | st_set;
		next_run = run;
		next_irq = |(status & mask);
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESET_N) begin
			aw_hold <= 1'b0;
			aw_addr <= '0;
			w_hold <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
			O_AWREADY <= 1'b0;
			O_WREADY <= 1'b0;
			O_BVALID <= 1'b0;
			O_BRESP <= gatc_pkg::RESP_OKAY;
			O_ARREADY <= 1'b0;
			O_RVALID <= 1'b0;
			O_RRESP <= gatc_pkg::RESP_OKAY;
			O_RDATA <= '0;
			ctrl <= gatc_pkg::CTRL_RESET[CW-2:0];
			rot_dir <= gatc_pkg::CTRL_RESET[gatc_pkg::ROTDIR_BIT];
			status <= gatc_pkg::ST_RESET;
			mask <= gatc_pkg::ST_RESET;
			bps <= gatc_pkg::BPS_RESET;
			cnt <= '0;
			toggle_prev <= 1'b0;
			O_CLEAR_AUX_A <= 1'b0;
			O_CLEAR_CORE <= 1'b0;
			O_AUX_B_RUN <= 1'b0;
			O_AUX_B_COUNT_DOWN <= 1'b0;
			O_IRQ <= 1'b0;
		end else begin
			aw_hold <= next_aw_hold;
			aw_addr <= next_aw_addr;
			w_hold <= next_w_hold;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			O_AWREADY <= next_awready;
			O_WREADY <= next_wready;
			O_BVALID <= next_bvalid;
			O_BRESP <= next_bresp;
			O_ARREADY <= next_arready;
			O_RVALID <= next_rvalid;
			O_RRESP <= next_rresp;
			O_RDATA <= next_rdata;
			ctrl <= next_ctrl;
			rot_dir <= next_rot_dir;
			status <= next_status;
			mask <= next_mask;
			bps <= next_bps;
			cnt <= next_cnt;
			toggle_prev <= I_CORE_TOGGLE_LATCH;
			O_CLEAR_AUX_A <= next_clear_a;
			O_CLEAR_CORE <= next_clear_core;
			O_AUX_B_RUN <= next_run;
			O_AUX_B_COUNT_DOWN <= next_rot_dir;
			O_IRQ <= next_irq;
		end
	end

endmodule

// ===== gatc_pkg.sv
package gatc_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h10;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h14;
	localparam logic [ADDR_W-1:0] MASK_ADDR = 8'h18;
	localparam logic [ADDR_W-1:0] CONFIG_ADDR = 8'h1C;
	localparam logic [ADDR_W-1:0] COUNT_ADDR = 8'h20;

	// ****************************************
	// Control register fields
	// ****************************************
	localparam int CTRL_W = 16;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
	localparam int INSEL_LSB = 0;
	localparam int MODE_LSB = 3;
	localparam int RUN_BIT = 6;
	localparam int SWDIR_BIT = 7;
	localparam int EXTDIR_BIT = 8;
	localparam int REMOTE_BIT = 9;
	localparam int CLR_A_BIT = 10;
	localparam int CLR_CORE_BIT = 11;
	localparam int IRQDIS_BIT = 12;
	localparam int EDGE_BIT = 13;
	localparam int DIRCHG_BIT = 14;
	localparam int ROTDIR_BIT = 15;

	// ****************************************
	// Interrupt status, mask and config
	// ****************************************
	localparam int ST_W = 4;
	localparam int ST_EDGE = 0;
	localparam int ST_DIRCHG = 1;
	localparam int ST_CLR_A = 2;
	localparam int ST_CLR_CORE = 3;
	localparam logic [ST_W-1:0] ST_RESET = 4'h0;
	localparam logic [1:0] BPS_RESET = 2'h0;

	// ****************************************
	// Encodings
	// ****************************************
	typedef enum logic [2:0] {
		MODE_TIMER = 3'b000,
		MODE_COUNTER = 3'b001,
		MODE_GATED_LO = 3'b010,
		MODE_GATED_HI = 3'b011,
		MODE_RELOAD = 3'b100,
		MODE_CAPTURE = 3'b101,
		MODE_INC_ROT = 3'b110,
		MODE_INC_EDGE = 3'b111
	} gatc_mode_t;

	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_ANY = 2'h3;
	localparam logic [2:0] INC_STOP = 3'h0;
	localparam logic [2:0] INC_COUNT_PIN = 3'h1;
	localparam logic [2:0] INC_DIR_PIN = 3'h2;
	localparam logic [2:0] INC_BOTH = 3'h3;

	localparam logic [1:0] BPS_DIV4 = 2'h1;
	localparam logic [1:0] BPS_DIV8 = 2'h0;
	localparam logic [1:0] BPS_DIV16 = 2'h3;
	localparam logic [1:0] BPS_DIV32 = 2'h2;
	localparam int PRESC_W = 12;
	localparam logic [3:0] PRESC_BASE_LOG2 = 4'h2;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== gatc_edge_if.sv
interface gatc_edge_if;
	logic level;
	logic rise;
	logic fall;

	modport drv (
		output level,
		output rise,
		output fall
	);
	modport use_side (
		input level,
		input rise,
		input fall
	);
endinterface

// ===== gatc_edge_sync.sv
module gatc_edge_sync (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_pin,
	gatc_edge_if.drv o_edge
);
	logic sync_a;
	logic sync_b;
	logic prev;
	logic next_sync_a;
	logic next_sync_b;
	logic next_prev;

	// Only sync_b reads sync_a; edges come from later stages
	always_comb begin
		next_sync_a = i_pin;
		next_sync_b = sync_a;
		next_prev = sync_b;
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			prev <= 1'b0;
		end else begin
			sync_a <= next_sync_a;
			sync_b <= next_sync_b;
			prev <= next_prev;
		end
	end

	assign o_edge.level = sync_b;
	assign o_edge.rise = sync_b & ~prev;
	assign o_edge.fall = ~sync_b & prev;
endmodule

// ===== gatc_prescaler.sv
module gatc_prescaler (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_enable,
	input wire logic [1:0] i_bps,
	input wire logic [2:0] i_sel,
	output logic o_tick
);
	logic [gatc_pkg::PRESC_W-1:0] cnt;
	logic [gatc_pkg::PRESC_W-1:0] next_cnt;
	logic [gatc_pkg::PRESC_W-1:0] terminal;
	logic [3:0] base_log2;
	logic [3:0] shift;

	// Non-linear common prescaler, then doubling per select step
	always_comb begin
		case (i_bps)
			gatc_pkg::BPS_DIV4: base_log2 = 4'h0;
			gatc_pkg::BPS_DIV8: base_log2 = 4'h1;
			gatc_pkg::BPS_DIV16: base_log2 = 4'h2;
			gatc_pkg::BPS_DIV32: base_log2 = 4'h3;
			default: base_log2 = 4'h0;
		endcase
		shift = base_log2 + i_sel + gatc_pkg::PRESC_BASE_LOG2;
		terminal = gatc_pkg::PRESC_W'((13'h0001 << shift) - 13'h0001);
		if (!i_enable || cnt >= terminal) begin
			next_cnt = '0;
		end else begin
			next_cnt = cnt + 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			cnt <= '0;
		end else begin
			cnt <= next_cnt;
		end
	end

	assign o_tick = i_enable && (cnt >= terminal);
endmodule

// ===== gatc_aux_timer_properties.sv
module gatc_aux_timer_properties (
	input wire logic I_CORE_CLK,
	input wire logic I_RESET_N,
	input wire logic [gatc_pkg::ADDR_W-1:0] I_ARADDR,
	input wire logic I_ARVALID,
	input wire logic O_ARREADY,
	input wire logic [gatc_pkg::DATA_W-1:0] O_RDATA,
	input wire logic [1:0] O_RRESP,
	input wire logic O_RVALID,
	input wire logic I_RREADY,
	input wire logic O_AWREADY,
	input wire logic O_WREADY,
	input wire logic [1:0] O_BRESP,
	input wire logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic O_CLEAR_AUX_A,
	input wire logic O_CLEAR_CORE,
	input wire logic O_AUX_B_COUNT_DOWN
);
	// ****************************************
	// Read address tracking
	// ****************************************
	logic [7:0] ar_q;
	logic [7:0] next_ar_q;
	logic ctrl_rd;
	logic map_rd;
	always_comb begin
		next_ar_q = (I_ARVALID && O_ARREADY) ? I_ARADDR : ar_q;
		if (!I_RESET_N) begin
			next_ar_q = 8'h00;
		end
		ctrl_rd = ar_q[7:2] == gatc_pkg::CTRL_ADDR[7:2];
		map_rd = ar_q[7:2] inside {[6'h04:6'h08]};
	end
	always_ff @(posedge I_CORE_CLK) begin
		ar_q <= next_ar_q;
	end
	// ****************************************
	// Properties
	// ****************************************
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RESET_N);
	sequence s_ar_taken;
		I_ARVALID && O_ARREADY;
	endsequence
	sequence s_ctrl_answer;
		$rose(O_RVALID) ##0 ctrl_rd;
	endsequence
	rd_latency_a: assert property (s_ar_taken |=> O_RVALID)
		else $error("read answer not one cycle after address");
	ar_block_a: assert property (O_RVALID |-> !O_ARREADY)
		else $error("read address accepted while answer pending");
	aw_block_a: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
		else $error("write accepted while response pending");
	bvalid_hold_a: assert property (O_BVALID && !I_BREADY |=>
		O_BVALID && $stable(O_BRESP))
		else $error("write response dropped before taken");
	rvalid_hold_a: assert property (O_RVALID && !I_RREADY |=>
		O_RVALID && $stable(O_RDATA))
		else $error("read data dropped before taken");
	unmapped_rd_a: assert property (O_RVALID && !map_rd |->
		O_RRESP == gatc_pkg::RESP_SLVERR && O_RDATA == 32'h0)
		else $error("unmapped read not refused");
	rot_mirror_a: assert property (s_ctrl_answer |->
		O_RDATA[15] == $past(O_AUX_B_COUNT_DOWN))
		else $error("rotation status differs from direction output");
	clr_core_pulse_a: assert property (O_CLEAR_CORE |=> !O_CLEAR_CORE)
		else $error("core clear longer than one cycle");
	clr_aux_pulse_a: assert property (O_CLEAR_AUX_A |=> !O_CLEAR_AUX_A)
		else $error("aux clear longer than one cycle");
endmodule

bind gatc_aux_timer gatc_aux_timer_properties u_props (
	.I_CORE_CLK(I_CORE_CLK), .I_RESET_N(I_RESET_N), .I_ARADDR(I_ARADDR),
	.I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA),
	.O_RRESP(O_RRESP), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY),
	.O_AWREADY(O_AWREADY), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP),
	.O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .O_CLEAR_AUX_A(O_CLEAR_AUX_A),
	.O_CLEAR_CORE(O_CLEAR_CORE), .O_AUX_B_COUNT_DOWN(O_AUX_B_COUNT_DOWN)
);

// ===== gatc_pin_model.sv
module gatc_pin_model #(
	parameter int HOLD = 3
) (
	input wire logic i_clk,
	input wire logic i_count_req,
	input wire logic i_dir_req,
	output logic o_count_pin,
	output logic o_direction_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Pin levels
	// ****************************************
	// Each level stands HOLD clocks so the synchroniser never misses it
	int hold = 0;
	initial begin
		o_count_pin = 1'b0;
		o_direction_pin = 1'b0;
	end
	always @(posedge i_clk) begin
		if (hold != 0) begin
			hold <= hold - 1;
		end else if ({i_count_req, i_dir_req} !=
			{o_count_pin, o_direction_pin}) begin
			o_count_pin <= i_count_req;
			o_direction_pin <= i_dir_req;
			hold <= HOLD - 1;
		end
	end
endmodule

// ===== gatc_aux_timer_test.sv
module gatc_aux_timer_test;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Stimulus and bench state
	// ****************************************
	logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0;
	logic arv = 1'b0, rrdy = 1'b0, cnt_req = 1'b0, dir_req = 1'b0;
	logic core_run = 1'b0, tgl = 1'b0, awr, wr_r, bv, arr, rv;
	logic clr_a, clr_c, run, down, irq, cpin, dpin;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rdata;
	logic [1:0] bresp, rresp;
	int n_errors = 0, tests_run = 0, n_ca = 0, n_cc = 0;
	localparam logic [1:0] OK = gatc_pkg::RESP_OKAY;
	always #2.5 clk = ~clk;
	always @(negedge clk) begin
		n_ca += (clr_a === 1'b1);
		n_cc += (clr_c === 1'b1);
	end
	gatc_pin_model pm (.i_clk(clk), .i_count_req(cnt_req), .i_dir_req(dir_req),
		.o_count_pin(cpin), .o_direction_pin(dpin));
	gatc_aux_timer dut (.I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_AWADDR(awa),
		.I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(4'hF),
		.I_WVALID(wv), .O_WREADY(wr_r), .O_BRESP(bresp), .O_BVALID(bv),
		.I_BREADY(brdy), .I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arr),
		.O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rv), .I_RREADY(rrdy),
		.I_AUX_B_COUNT_PIN(cpin), .I_AUX_B_DIRECTION_PIN(dpin),
		.I_CORE_RUN_BIT(core_run), .I_CORE_TOGGLE_LATCH(tgl),
		.O_CLEAR_AUX_A(clr_a), .O_CLEAR_CORE(clr_c), .O_AUX_B_RUN(run),
		.O_AUX_B_COUNT_DOWN(down), .O_IRQ(irq));
	// ****************************************
	// Bus and compare tasks
	// ****************************************
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic a_ok, w_ok, b_ok;
		logic [1:0] r;
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		b_ok = 1'b0;
		while (!b_ok) begin
			@(negedge clk);
			a_ok = awr === 1'b1;
			w_ok = wr_r === 1'b1;
			b_ok = bv === 1'b1;
			r = bresp;
			@(posedge clk);
			if (a_ok) awv <= 1'b0;
			if (w_ok) wv <= 1'b0;
		end
		brdy <= 1'b0;
		chk("bresp", er, r);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic a_ok, ok;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rrdy <= 1'b1;
		ok = 1'b0;
		while (!ok) begin
			@(negedge clk);
			a_ok = arr === 1'b1;
			ok = rv === 1'b1;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (a_ok) arv <= 1'b0;
		end
		rrdy <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk("read data", e, d);
		chk("rresp", er, r);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	function automatic logic dirf(input logic p, input logic ude, input logic ud);
		return ude ? p ^ ud : ud;
	endfunction
	task automatic test_done();
		if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		rc(gatc_pkg::CTRL_ADDR, 32'h0, OK);
		rc(gatc_pkg::STATUS_ADDR, 32'h0, OK);
		rc(gatc_pkg::MASK_ADDR, 32'h0, OK);
		rc(8'h04, 32'h0, gatc_pkg::RESP_SLVERR);
		w(8'h04, 32'hF, gatc_pkg::RESP_SLVERR);
		w(gatc_pkg::CTRL_ADDR, 32'h1F7F, OK);
		rc(gatc_pkg::CTRL_ADDR, 32'h1F7F, OK);
		w(gatc_pkg::CTRL_ADDR, 32'h0, OK);
	endtask
	task automatic t_dir();
		logic [3:0] rows [6] = '{4'h0, 4'hB, 4'h4, 4'hD, 4'h7, 4'hE};
		logic ude, ud, mid, fin;
		ude = 1'b0;
		ud = 1'b0;
		for (int i = 0; i < 6; i++) begin
			dir_req <= rows[i][3];
			cyc(8);
			mid = dirf(rows[i][3], ude, ud);
			ude = rows[i][2];
			ud = rows[i][1];
			fin = dirf(rows[i][3], ude, ud);
			chk("table row", rows[i][0], fin);
			w(gatc_pkg::CTRL_ADDR, {23'h0, ude, ud, 7'h0}, OK);
			cyc(7);
			@(negedge clk);
			chk("count down", fin, down);
			rc(gatc_pkg::CTRL_ADDR, {16'h0, fin, fin != mid, 5'h0, ude, ud, 7'h0},
				OK);
		end
		dir_req <= 1'b0;
		w(gatc_pkg::CTRL_ADDR, 32'h0, OK);
	endtask
	task automatic t_count();
		logic [11:0] ctl [11] = '{12'h048, 12'h049, 12'h04A, 12'h04B, 12'h04C,
			12'h04D, 12'h04E, 12'h04F, 12'h00B, 12'h20B, 12'h24B};
		logic [1:0] ex [11] = '{0, 1, 1, 2, 0, 1, 1, 2, 0, 2, 0};
		for (int i = 0; i < 11; i++) begin
			core_run <= (i == 9);
			w(gatc_pkg::COUNT_ADDR, 32'h0, OK);
			w(gatc_pkg::CTRL_ADDR, {20'h0, ctl[i]}, OK);
			cyc(3);
			@(negedge clk);
			chk("run", ctl[i][9] ? (i == 9) : ctl[i][6], run);
			@(posedge clk);
			cnt_req <= 1'b1;
			cyc(8);
			cnt_req <= 1'b0;
			cyc(8);
			tgl <= 1'b1;
			cyc(4);
			tgl <= 1'b0;
			cyc(8);
			rc(gatc_pkg::COUNT_ADDR, {30'h0, ex[i]}, OK);
			rc(gatc_pkg::CTRL_ADDR, {18'h0, ex[i] != 0, 1'b0, ctl[i]}, OK);
		end
		core_run <= 1'b0;
	endtask
	task automatic t_timer();
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 2; i++) begin
			w(gatc_pkg::CONFIG_ADDR, i ? 32'h2 : 32'h1, OK);
			rc(gatc_pkg::CONFIG_ADDR, i ? 32'h2 : 32'h1, OK);
			w(gatc_pkg::COUNT_ADDR, 32'h0, OK);
			w(gatc_pkg::CTRL_ADDR, {31'h0, i[0]} | 32'h40, OK);
			cyc(i ? 6400 : 400);
			w(gatc_pkg::CTRL_ADDR, 32'h0, OK);
			rd(gatc_pkg::COUNT_ADDR, d, r);
			chk("timer count near 100", 1, d >= 98 && d <= 103);
		end
	endtask
	task automatic t_incr();
		w(gatc_pkg::COUNT_ADDR, 32'h0, OK);
		for (int i = 0; i < 2; i++) begin
			w(gatc_pkg::STATUS_ADDR, 32'hF, OK);
			w(gatc_pkg::CTRL_ADDR, i ? 32'h1072 : 32'h0073, OK);
			cnt_req <= 1'b1;
			cyc(8);
			cnt_req <= 1'b0;
			cyc(8);
			dir_req <= 1'b1;
			cyc(8);
			dir_req <= 1'b0;
			cyc(8);
			rc(gatc_pkg::COUNT_ADDR, i ? 32'h6 : 32'h4, OK);
			rc(gatc_pkg::STATUS_ADDR, i ? 32'h0 : 32'h1, OK);
			rc(gatc_pkg::CTRL_ADDR, i ? 32'h3072 : 32'h2073, OK);
		end
		w(gatc_pkg::CTRL_ADDR, 32'h0069, OK);
		cnt_req <= 1'b1;
		cyc(8);
		cnt_req <= 1'b0;
		cyc(8);
		rc(gatc_pkg::CTRL_ADDR, 32'h2069, OK);
		rc(gatc_pkg::COUNT_ADDR, 32'h6, OK);
		w(gatc_pkg::CTRL_ADDR, 32'h0, OK);
	endtask
	task automatic t_clear();
		for (int i = 0; i < 2; i++) begin
			w(gatc_pkg::CTRL_ADDR, i ? 32'h0 : 32'hC00, OK);
			n_ca = 0;
			n_cc = 0;
			cnt_req <= 1'b1;
			dir_req <= 1'b1;
			cyc(8);
			cnt_req <= 1'b0;
			dir_req <= 1'b0;
			cyc(10);
			chk("core clears", i ? 0 : 1, n_cc);
			chk("aux clears", i ? 0 : 1, n_ca);
		end
		@(negedge clk);
		chk("irq masked", 1'b0, irq);
		w(gatc_pkg::MASK_ADDR, 32'hC, OK);
		cyc(1);
		@(negedge clk);
		chk("irq", 1'b1, irq);
		w(gatc_pkg::STATUS_ADDR, 32'hF, OK);
		cyc(1);
		@(negedge clk);
		chk("irq cleared", 1'b0, irq);
		rc(gatc_pkg::STATUS_ADDR, 32'h0, OK);
	endtask
	initial begin
		#200us;
		n_errors++;
		test_done();
	end
	initial begin
		cyc(8);
		rst_n <= 1'b1;
		t_reset();
		t_dir();
		t_count();
		t_timer();
		t_incr();
		t_clear();
		test_done();
	end
endmodule
